// ---- dmacc_chan.sv ----
package dmacc_pkg;
   // Register codes within a channel's group on the write/read select
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_SRC_LO = 3'h1;
   localparam logic [2:0] REG_SRC_HI = 3'h2;
   localparam logic [2:0] REG_DST_LO = 3'h3;
   localparam logic [2:0] REG_DST_HI = 3'h4;
   localparam logic [2:0] REG_COUNT = 3'h5;
   localparam logic [2:0] REG_PRIO = 3'h7;
   // channel_control field positions
   localparam int B_DEST_IN_MEMORY = 15;
   localparam int B_DEST_DECREMENT = 14;
   localparam int B_DEST_INCREMENT = 13;
   localparam int B_SRC_IN_MEMORY = 12;
   localparam int B_SRC_DECREMENT = 11;
   localparam int B_SRC_INCREMENT = 10;
   localparam int B_STOP_AT_COUNT_END = 9;
   localparam int B_IRQ_AT_COUNT_END = 8;
   localparam int B_PACING_HI = 7;
   localparam int B_PACING_LO = 6;
   localparam int B_CHAN_RANK_HIGH = 5;
   localparam int B_INTERNAL_SOURCE_SELECT = 4;
   localparam int B_START_WRITE_ENABLE = 2;
   localparam int B_ARM_CHANNEL = 1;
   localparam int B_WORD_SIZE = 0;
   localparam logic [15:0] CTRL_WRITE_MASK = 16'hFFF7;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // module_priority_and_source field positions
   localparam int B_MODULE_A_HIGH_RANK = 0;
   localparam int B_MODULE_B_HIGH_RANK = 1;
   localparam int B_MODULE_A_SERIAL_SOURCE = 2;
   localparam int B_MODULE_B_SERIAL_SOURCE = 3;
   localparam logic [3:0] PRIO_RESET = 4'h0;
   localparam logic [19:0] PTR_RESET = 20'h00000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [19:0] STEP_WORD = 20'h00002;
   localparam logic [19:0] STEP_BYTE = 20'h00001;
   localparam logic [1:0] PACE_UNSYNC = 2'h0;
   localparam logic [1:0] PACE_SRC = 2'h1;
   localparam logic [1:0] PACE_DST = 2'h2;
   typedef enum logic {DMACC_IDLE, DMACC_BUSY} dmacc_state_t;
endpackage : dmacc_pkg

module dmacc_chan #(
   parameter bit NARROW_BUS = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [2:0] wr_reg,
   input wire logic [15:0] wr_data,
   input wire logic int_req,
   input wire logic ext_req,
   input wire logic step,
   output logic [15:0] ctrl_q,
   output logic [19:0] src_q,
   output logic [19:0] dst_q,
   output logic [15:0] cnt_q,
   output logic want,
   output logic irq_q
);
   logic [15:0] ctrl_d;
   logic [19:0] src_d;
   logic [19:0] dst_d;
   logic [15:0] cnt_d;
   logic arm_q;
   logic arm_d;

   wire wr_ctrl = wr_en && (wr_reg == dmacc_pkg::REG_CTRL);
   wire [1:0] pacing = ctrl_q[dmacc_pkg::B_PACING_HI:dmacc_pkg::B_PACING_LO];
   wire unsync = (pacing == dmacc_pkg::PACE_UNSYNC);
   wire paced = (pacing == dmacc_pkg::PACE_SRC) || (pacing == dmacc_pkg::PACE_DST);
   wire word_eff = ctrl_q[dmacc_pkg::B_WORD_SIZE] & ~NARROW_BUS;
   wire [19:0] delta = word_eff ? dmacc_pkg::STEP_WORD : dmacc_pkg::STEP_BYTE;
   wire [15:0] cnt_next = cnt_q - 16'h0001;
   wire at_end = step && (cnt_next == 16'h0000);
   wire stop_eff = ctrl_q[dmacc_pkg::B_STOP_AT_COUNT_END] | unsync;
   wire tc_stop = at_end && stop_eff;
   wire irq_d = at_end && ctrl_q[dmacc_pkg::B_IRQ_AT_COUNT_END] && ctrl_q[dmacc_pkg::B_STOP_AT_COUNT_END];
   wire sel_req = ctrl_q[dmacc_pkg::B_INTERNAL_SOURCE_SELECT] ? int_req : ext_req;

   // Unsynchronized channels request for as long as they stay armed
   assign want = arm_q && !tc_stop && (unsync || (paced && sel_req));

   function automatic logic [19:0] index_ptr(input logic [19:0] p, input logic inc, input logic dec,
                                             input logic [19:0] d);
      logic [19:0] r;
      r = p;
      if (inc && !dec) begin
         r = p + d;
      end else if (dec && !inc) begin
         r = p - d;
      end
      return r;
   endfunction : index_ptr

   always_comb begin
      ctrl_d = ctrl_q;
      arm_d = arm_q;
      src_d = src_q;
      dst_d = dst_q;
      cnt_d = cnt_q;
      if (step) begin
         src_d = index_ptr(src_q, ctrl_q[dmacc_pkg::B_SRC_INCREMENT], ctrl_q[dmacc_pkg::B_SRC_DECREMENT], delta);
         dst_d = index_ptr(dst_q, ctrl_q[dmacc_pkg::B_DEST_INCREMENT], ctrl_q[dmacc_pkg::B_DEST_DECREMENT], delta);
         cnt_d = cnt_next;
      end
      if (tc_stop) begin
         arm_d = 1'b0;
      end
      // Software writes win over a same-cycle transfer update
      if (wr_ctrl) begin
         ctrl_d = wr_data & dmacc_pkg::CTRL_WRITE_MASK;
         if (wr_data[dmacc_pkg::B_START_WRITE_ENABLE]) begin
            arm_d = wr_data[dmacc_pkg::B_ARM_CHANNEL];
         end
      end
      if (wr_en && (wr_reg == dmacc_pkg::REG_SRC_LO)) begin
         src_d = {src_q[19:16], wr_data};
      end
      if (wr_en && (wr_reg == dmacc_pkg::REG_SRC_HI)) begin
         src_d = {wr_data[3:0], src_q[15:0]};
      end
      if (wr_en && (wr_reg == dmacc_pkg::REG_DST_LO)) begin
         dst_d = {dst_q[19:16], wr_data};
      end
      if (wr_en && (wr_reg == dmacc_pkg::REG_DST_HI)) begin
         dst_d = {wr_data[3:0], dst_q[15:0]};
      end
      if (wr_en && (wr_reg == dmacc_pkg::REG_COUNT)) begin
         cnt_d = wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q <= dmacc_pkg::CTRL_RESET;
         arm_q <= 1'b0;
         src_q <= dmacc_pkg::PTR_RESET;
         dst_q <= dmacc_pkg::PTR_RESET;
         cnt_q <= dmacc_pkg::COUNT_RESET;
         irq_q <= 1'b0;
      end else begin
         ctrl_q <= {ctrl_d[15:2], arm_d, ctrl_d[0]};
         arm_q <= arm_d;
         src_q <= src_d;
         dst_q <= dst_d;
         cnt_q <= cnt_d;
         irq_q <= irq_d;
      end
   end
endmodule : dmacc_chan

// ---- dmacc_top.sv ----
module dmacc_top #(
   parameter bit NARROW_BUS = 1'b0
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic WR_EN,
   input wire logic [4:0] WR_SEL,
   input wire logic [15:0] WR_DATA,
   input wire logic [4:0] RD_SEL,
   output logic [15:0] RD_DATA,
   input wire logic [3:0] EXT_REQUEST_PIN,
   input wire logic TIMER2_REQ,
   input wire logic [1:0] SERIAL_TX_REQ,
   input wire logic [1:0] SERIAL_RX_REQ,
   output logic XFER_VALID,
   output logic [1:0] XFER_CHAN,
   output logic [19:0] XFER_SRC_ADDR,
   output logic XFER_SRC_MEM,
   output logic [19:0] XFER_DST_ADDR,
   output logic XFER_DST_MEM,
   output logic XFER_WORD,
   input wire logic XFER_DONE,
   output logic [3:0] DMA_IRQ
);
   logic [15:0] ctrl [4];
   logic [19:0] src [4];
   logic [19:0] dst [4];
   logic [15:0] cnt [4];
   logic [3:0] want;
   logic [3:0] step;
   logic [3:0] int_req;
   logic [3:0] prio_q;
   logic [1:0] chan_rot_q;
   logic mod_rot_q;
   dmacc_pkg::dmacc_state_t state_q;
   logic [1:0] sel_q;
   logic [15:0] rd_mux;

   wire wr_prio = WR_EN && (WR_SEL[2:0] == dmacc_pkg::REG_PRIO);
   wire ser_a = prio_q[dmacc_pkg::B_MODULE_A_SERIAL_SOURCE];
   wire ser_b = prio_q[dmacc_pkg::B_MODULE_B_SERIAL_SOURCE];

   // One source select per module keeps both channels on the same source
   assign int_req[0] = ser_a ? SERIAL_TX_REQ[0] : TIMER2_REQ;
   assign int_req[1] = ser_a ? SERIAL_RX_REQ[0] : TIMER2_REQ;
   assign int_req[2] = ser_b ? SERIAL_TX_REQ[1] : TIMER2_REQ;
   assign int_req[3] = ser_b ? SERIAL_RX_REQ[1] : TIMER2_REQ;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         dmacc_chan #(.NARROW_BUS(NARROW_BUS)) u_chan (
            .clk(CLK),
            .reset(RESET),
            .wr_en(WR_EN && (WR_SEL[4:3] == 2'(g)) && !wr_prio),
            .wr_reg(WR_SEL[2:0]),
            .wr_data(WR_DATA),
            .int_req(int_req[g]),
            .ext_req(EXT_REQUEST_PIN[g]),
            .step(step[g]),
            .ctrl_q(ctrl[g]),
            .src_q(src[g]),
            .dst_q(dst[g]),
            .cnt_q(cnt[g]),
            .want(want[g]),
            .irq_q(DMA_IRQ[g])
         );
      end
   endgenerate

   // Channel pick within each module
   wire rank0_a = ctrl[0][dmacc_pkg::B_CHAN_RANK_HIGH];
   wire rank1_a = ctrl[1][dmacc_pkg::B_CHAN_RANK_HIGH];
   wire rank0_b = ctrl[2][dmacc_pkg::B_CHAN_RANK_HIGH];
   wire rank1_b = ctrl[3][dmacc_pkg::B_CHAN_RANK_HIGH];
   wire both_a = want[0] && want[1];
   wire both_b = want[2] && want[3];
   wire pick_a = both_a ? ((rank0_a != rank1_a) ? rank1_a : chan_rot_q[0]) : want[1];
   wire pick_b = both_b ? ((rank0_b != rank1_b) ? rank1_b : chan_rot_q[1]) : want[3];
   wire req_a = want[0] || want[1];
   wire req_b = want[2] || want[3];

   // Module pick
   wire mrank_a = prio_q[dmacc_pkg::B_MODULE_A_HIGH_RANK];
   wire mrank_b = prio_q[dmacc_pkg::B_MODULE_B_HIGH_RANK];
   wire pick_mod = (req_a && req_b) ? ((mrank_a != mrank_b) ? mrank_b : mod_rot_q) : req_b;
   wire [1:0] winner = pick_mod ? {1'b1, pick_b} : {1'b0, pick_a};
   wire grant = (state_q == dmacc_pkg::DMACC_IDLE) && (req_a || req_b);
   wire finish = (state_q == dmacc_pkg::DMACC_BUSY) && XFER_DONE;

   assign XFER_VALID = (state_q == dmacc_pkg::DMACC_BUSY);
   assign XFER_CHAN = sel_q;
   assign step = finish ? (4'h1 << sel_q) : 4'h0;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_q <= dmacc_pkg::DMACC_IDLE;
         sel_q <= 2'h0;
      end else begin
         case (state_q)
            dmacc_pkg::DMACC_IDLE: begin
               if (grant) begin
                  state_q <= dmacc_pkg::DMACC_BUSY;
                  sel_q <= winner;
               end
            end
            dmacc_pkg::DMACC_BUSY: begin
               if (XFER_DONE) begin
                  state_q <= dmacc_pkg::DMACC_IDLE;
               end
            end
            default: begin
               state_q <= dmacc_pkg::DMACC_IDLE;
            end
         endcase
      end
   end

   // After serving, a channel and its module drop to the back of the rotation
   always_ff @(posedge CLK) begin
      if (RESET) begin
         chan_rot_q <= 2'h0;
         mod_rot_q <= 1'b1;
      end else if (finish) begin
         chan_rot_q[sel_q[1]] <= ~sel_q[0];
         mod_rot_q <= ~sel_q[1];
      end
   end

   // Transfer description latched at grant
   always_ff @(posedge CLK) begin
      if (RESET) begin
         XFER_SRC_ADDR <= dmacc_pkg::PTR_RESET;
         XFER_DST_ADDR <= dmacc_pkg::PTR_RESET;
         XFER_SRC_MEM <= 1'b0;
         XFER_DST_MEM <= 1'b0;
         XFER_WORD <= 1'b0;
      end else if (grant) begin
         XFER_SRC_ADDR <= src[winner];
         XFER_DST_ADDR <= dst[winner];
         XFER_SRC_MEM <= ctrl[winner][dmacc_pkg::B_SRC_IN_MEMORY];
         XFER_DST_MEM <= ctrl[winner][dmacc_pkg::B_DEST_IN_MEMORY];
         XFER_WORD <= ctrl[winner][dmacc_pkg::B_WORD_SIZE] & ~NARROW_BUS;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         prio_q <= dmacc_pkg::PRIO_RESET;
      end else if (wr_prio) begin
         prio_q <= WR_DATA[3:0];
      end
   end

   wire [1:0] rd_ch = RD_SEL[4:3];
   always_comb begin
      case (RD_SEL[2:0])
         dmacc_pkg::REG_CTRL: rd_mux = ctrl[rd_ch];
         dmacc_pkg::REG_SRC_LO: rd_mux = src[rd_ch][15:0];
         dmacc_pkg::REG_SRC_HI: rd_mux = {12'h000, src[rd_ch][19:16]};
         dmacc_pkg::REG_DST_LO: rd_mux = dst[rd_ch][15:0];
         dmacc_pkg::REG_DST_HI: rd_mux = {12'h000, dst[rd_ch][19:16]};
         dmacc_pkg::REG_COUNT: rd_mux = cnt[rd_ch];
         dmacc_pkg::REG_PRIO: rd_mux = {12'h000, prio_q};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         RD_DATA <= 16'h0000;
      end else begin
         RD_DATA <= rd_mux;
      end
   end
endmodule : dmacc_top

// ---- dmacc_asserts.sv ----
module dmacc_asserts #(
   parameter bit NARROW_BUS = 1'b0
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [4:0] RD_SEL,
   input wire logic [15:0] RD_DATA,
   input wire logic XFER_VALID,
   input wire logic [1:0] XFER_CHAN,
   input wire logic [19:0] XFER_SRC_ADDR,
   input wire logic XFER_SRC_MEM,
   input wire logic [19:0] XFER_DST_ADDR,
   input wire logic XFER_DST_MEM,
   input wire logic XFER_WORD,
   input wire logic XFER_DONE,
   input wire logic [3:0] DMA_IRQ
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [2:0] rd_reg = RD_SEL[2:0];
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   property p_hold;
      XFER_VALID && !XFER_DONE |=> XFER_VALID && $stable({XFER_CHAN, XFER_SRC_ADDR, XFER_DST_ADDR,
         XFER_SRC_MEM, XFER_DST_MEM, XFER_WORD});
   endproperty
   a_hold: assert property (p_hold) else $error("transfer fields moved before completion");
   property p_gap;
      XFER_VALID && XFER_DONE |=> !XFER_VALID;
   endproperty
   a_gap: assert property (p_gap) else $error("transfer not retired after completion");
   property p_irq_chan;
      DMA_IRQ != 4'h0 |-> $past(XFER_VALID) && $past(XFER_DONE) && DMA_IRQ == (4'h1 << $past(XFER_CHAN));
   endproperty
   a_irq_chan: assert property (p_irq_chan) else $error("interrupt not tied to finished channel");
   property p_irq_pulse;
      DMA_IRQ != 4'h0 |=> DMA_IRQ == 4'h0;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
   property p_narrow;
      XFER_VALID |-> !(NARROW_BUS && XFER_WORD);
   endproperty
   a_narrow: assert property (p_narrow) else $error("word transfer on narrow bus");
   property p_rst;
      $fell(RESET) |-> !XFER_VALID && DMA_IRQ == 4'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("activity right after reset");
   property p_ctrl_res;
      $past(rd_reg) == dmacc_pkg::REG_CTRL |-> RD_DATA[3] == 1'b0;
   endproperty
   a_ctrl_res: assert property (p_ctrl_res) else $error("reserved control bit reads set");
   property p_prio_res;
      $past(rd_reg) == dmacc_pkg::REG_PRIO |-> RD_DATA[15:4] == 12'h000;
   endproperty
   a_prio_res: assert property (p_prio_res) else $error("upper priority bits read set");
   c_done: cover property (XFER_VALID && XFER_DONE);
   c_irq: cover property (DMA_IRQ != 4'h0);
   c_word: cover property (XFER_VALID && XFER_WORD);
endmodule : dmacc_asserts

bind dmacc_top dmacc_asserts #(.NARROW_BUS(NARROW_BUS)) u_chk (.CLK(CLK), .RESET(RESET), .RD_SEL(RD_SEL),
   .RD_DATA(RD_DATA), .XFER_VALID(XFER_VALID), .XFER_CHAN(XFER_CHAN), .XFER_SRC_ADDR(XFER_SRC_ADDR),
   .XFER_SRC_MEM(XFER_SRC_MEM), .XFER_DST_ADDR(XFER_DST_ADDR), .XFER_DST_MEM(XFER_DST_MEM),
   .XFER_WORD(XFER_WORD), .XFER_DONE(XFER_DONE), .DMA_IRQ(DMA_IRQ));

// ---- dmacc_partner.sv ----
module dmacc_partner (
   input wire logic clk,
   input wire logic reset,
   input wire logic xfer_valid,
   output logic xfer_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] wait_q;
   logic slow_q;
   // Alternates prompt and slow completion, one-cycle done pulse
   always @(posedge clk) begin
      if (reset || !xfer_valid || xfer_done) begin
         wait_q <= 3'h0;
         xfer_done <= 1'b0;
      end else begin
         wait_q <= wait_q + 3'h1;
         xfer_done <= (wait_q == (slow_q ? 3'h3 : 3'h0));
      end
      slow_q <= reset ? 1'b0 : slow_q ^ xfer_done;
   end
endmodule : dmacc_partner

// ---- tb_dma_channel_config_control.sv ----
module tb_dma_channel_config_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0, RESET = 1'b1, WR_EN = 1'b0, TIMER2_REQ = 1'b0, XFER_DONE;
   logic [4:0] WR_SEL = 5'h00, RD_SEL = 5'h00;
   logic [15:0] WR_DATA = 16'h0000, RD_DATA;
   logic [3:0] EXT_REQUEST_PIN = 4'h0, DMA_IRQ, irq_acc;
   logic [1:0] SERIAL_TX_REQ = 2'h0, SERIAL_RX_REQ = 2'h0, XFER_CHAN;
   logic XFER_VALID, XFER_SRC_MEM, XFER_DST_MEM, XFER_WORD;
   logic [19:0] XFER_SRC_ADDR, XFER_DST_ADDR;
   int mismatches = 0, n_compared = 0;
   always #25 CLK = ~CLK;
   always @(posedge CLK) irq_acc <= irq_acc | DMA_IRQ;
   dmacc_top dut (.CLK(CLK), .RESET(RESET), .WR_EN(WR_EN), .WR_SEL(WR_SEL), .WR_DATA(WR_DATA), .RD_SEL(RD_SEL),
      .RD_DATA(RD_DATA), .EXT_REQUEST_PIN(EXT_REQUEST_PIN), .TIMER2_REQ(TIMER2_REQ), .SERIAL_TX_REQ(SERIAL_TX_REQ),
      .SERIAL_RX_REQ(SERIAL_RX_REQ), .XFER_VALID(XFER_VALID), .XFER_CHAN(XFER_CHAN), .XFER_SRC_ADDR(XFER_SRC_ADDR),
      .XFER_SRC_MEM(XFER_SRC_MEM), .XFER_DST_ADDR(XFER_DST_ADDR), .XFER_DST_MEM(XFER_DST_MEM),
      .XFER_WORD(XFER_WORD), .XFER_DONE(XFER_DONE), .DMA_IRQ(DMA_IRQ));
   dmacc_partner u_far (.clk(CLK), .reset(RESET), .xfer_valid(XFER_VALID), .xfer_done(XFER_DONE));
   task chk(input logic [47:0] seen, input logic [47:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wc(input logic [1:0] ch, input logic [2:0] rg, input logic [15:0] d);
      WR_SEL = {ch, rg};
      WR_DATA = d;
      WR_EN = 1'b1;
      @(posedge CLK) #1 WR_EN = 1'b0;
      @(posedge CLK) #1;
   endtask : wc
   task rd(input logic [1:0] ch, input logic [2:0] rg, input logic [15:0] exp);
      RD_SEL = {ch, rg};
      repeat (2) @(posedge CLK);
      #1 chk(RD_DATA, exp);
   endtask : rd
   task novalid(input int n);
      repeat (n) @(posedge CLK) #1 chk(XFER_VALID, 1'b0);
   endtask : novalid
   // Waits for one transfer, judges its fields, then waits for it to retire
   task xf(input logic [1:0] ch, input logic [19:0] s, input logic [19:0] d, input logic sm, dm, w);
      for (int i = 0; i < 40 && XFER_VALID !== 1'b1; i++) @(posedge CLK) #1;
      chk({XFER_VALID, XFER_CHAN, XFER_SRC_ADDR, XFER_DST_ADDR, XFER_SRC_MEM, XFER_DST_MEM, XFER_WORD},
         {1'b1, ch, s, d, sm, dm, w});
      for (int i = 0; i < 40 && XFER_VALID !== 1'b0; i++) @(posedge CLK) #1;
      chk(XFER_VALID, 1'b0);
   endtask : xf
   task t_reset();
      for (int c = 0; c < 4; c++) rd(c[1:0], dmacc_pkg::REG_CTRL, 16'h0000);
      rd(2'h0, dmacc_pkg::REG_PRIO, 16'h0000);
      $display("test reset done");
   endtask : t_reset
   task t_arm_gate();
      wc(2'h2, dmacc_pkg::REG_CTRL, 16'hA503);
      novalid(8);
      rd(2'h2, dmacc_pkg::REG_CTRL, 16'hA501);
      $display("test arm gate done");
   endtask : t_arm_gate
   task t_unsync();
      wc(2'h1, dmacc_pkg::REG_SRC_LO, 16'h2345);
      wc(2'h1, dmacc_pkg::REG_SRC_HI, 16'h0001);
      wc(2'h1, dmacc_pkg::REG_DST_LO, 16'hABCD);
      wc(2'h1, dmacc_pkg::REG_DST_HI, 16'h0000);
      wc(2'h1, dmacc_pkg::REG_COUNT, 16'h0002);
      irq_acc = 4'h0;
      wc(2'h1, dmacc_pkg::REG_CTRL, 16'hC507);
      xf(2'h1, 20'h12345, 20'h0ABCD, 1'b0, 1'b1, 1'b1);
      xf(2'h1, 20'h12347, 20'h0ABCB, 1'b0, 1'b1, 1'b1);
      novalid(10);
      rd(2'h1, dmacc_pkg::REG_CTRL, 16'hC505);
      rd(2'h1, dmacc_pkg::REG_COUNT, 16'h0000);
      chk(irq_acc, 4'h0);
      $display("test unsynchronized done");
   endtask : t_unsync
   task t_internal();
      wc(2'h3, dmacc_pkg::REG_SRC_LO, 16'h0010);
      wc(2'h3, dmacc_pkg::REG_SRC_HI, 16'h0000);
      wc(2'h3, dmacc_pkg::REG_DST_LO, 16'h0300);
      wc(2'h3, dmacc_pkg::REG_DST_HI, 16'h000F);
      wc(2'h3, dmacc_pkg::REG_COUNT, 16'h0002);
      wc(2'h0, dmacc_pkg::REG_PRIO, 16'h0008);
      TIMER2_REQ = 1'b1;
      EXT_REQUEST_PIN = 4'h9;
      SERIAL_TX_REQ = 2'h2;
      wc(2'h0, dmacc_pkg::REG_CTRL, 16'h00C6);
      irq_acc = 4'h0;
      wc(2'h3, dmacc_pkg::REG_CTRL, 16'h7B56);
      novalid(12);
      SERIAL_RX_REQ = 2'h2;
      xf(2'h3, 20'h00010, 20'hF0300, 1'b1, 1'b0, 1'b0);
      xf(2'h3, 20'h0000F, 20'hF0300, 1'b1, 1'b0, 1'b0);
      SERIAL_RX_REQ = 2'h0;
      novalid(6);
      chk(irq_acc, 4'h8);
      rd(2'h3, dmacc_pkg::REG_CTRL, 16'h7B54);
      rd(2'h0, dmacc_pkg::REG_PRIO, 16'h0008);
      $display("test internal request done");
   endtask : t_internal
   // Fixed module and channel ranks first, then equal ranks rotate
   task t_arbitrate();
      TIMER2_REQ = 1'b0;
      EXT_REQUEST_PIN = 4'h0;
      wc(2'h0, dmacc_pkg::REG_PRIO, 16'h0001);
      wc(2'h0, dmacc_pkg::REG_CTRL, 16'h20A6);
      wc(2'h1, dmacc_pkg::REG_CTRL, 16'h0086);
      wc(2'h2, dmacc_pkg::REG_CTRL, 16'h0056);
      novalid(4);
      TIMER2_REQ = 1'b1;
      EXT_REQUEST_PIN = 4'h3;
      xf(2'h0, 20'h00000, 20'h00000, 1'b0, 1'b0, 1'b0);
      xf(2'h0, 20'h00000, 20'h00001, 1'b0, 1'b0, 1'b0);
      TIMER2_REQ = 1'b0;
      EXT_REQUEST_PIN = 4'h0;
      wc(2'h0, dmacc_pkg::REG_PRIO, 16'h0000);
      wc(2'h0, dmacc_pkg::REG_CTRL, 16'h2086);
      TIMER2_REQ = 1'b1;
      EXT_REQUEST_PIN = 4'h3;
      xf(2'h2, 20'h00000, 20'h00000, 1'b0, 1'b0, 1'b0);
      xf(2'h1, 20'h12349, 20'h0ABC9, 1'b0, 1'b0, 1'b0);
      xf(2'h2, 20'h00000, 20'h00000, 1'b0, 1'b0, 1'b0);
      xf(2'h0, 20'h00000, 20'h00002, 1'b0, 1'b0, 1'b0);
      EXT_REQUEST_PIN = 4'h0;
      xf(2'h2, 20'h00000, 20'h00000, 1'b0, 1'b0, 1'b0);
      TIMER2_REQ = 1'b0;
      EXT_REQUEST_PIN = 4'h4;
      novalid(4);
      EXT_REQUEST_PIN = 4'h0;
      $display("test arbitration done");
   endtask : t_arbitrate
   // Reset lands with a channel 2 transfer outstanding, just after a priority write that it must clear
   task t_mid_reset();
      wc(2'h0, dmacc_pkg::REG_PRIO, 16'h000F);
      RESET = 1'b1;
      repeat (2) @(posedge CLK);
      #1 RESET = 1'b0;
      rd(2'h0, dmacc_pkg::REG_CTRL, 16'h0000);
      rd(2'h0, dmacc_pkg::REG_PRIO, 16'h0000);
      novalid(4);
      $display("test mid-run reset done");
   endtask : t_mid_reset
   task tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   initial begin
      #400000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      irq_acc = 4'h0;
      repeat (4) @(posedge CLK);
      #1 RESET = 1'b0;
      t_reset();
      t_arm_gate();
      t_unsync();
      t_internal();
      t_arbitrate();
      t_mid_reset();
      tally_and_finish();
   end
endmodule : tb_dma_channel_config_control
